// ### verilog/mtc_map.svh
// Constants for the machine trap cause and return unit.
// Assumes inclusion by bare name from the design files.
`ifndef MTC_MAP_SVH
`define MTC_MAP_SVH
`define MTC_XLEN 64
`define MTC_ADR_EPC 4'h0
`define MTC_ADR_CAUSE 4'h1
`define MTC_ADR_BAD 4'h2
`define MTC_ADR_STAT 4'h3
`define MTC_ADR_PCLO 4'h4
`define MTC_ADR_PCHI 4'h5
`define MTC_ADR_IE 4'h6
`define MTC_ADR_RSTV 4'h7
`define MTC_CODE_W 4
`define MTC_CODE_MAX_INT 4'hb
`define MTC_CODE_MAX_EXC 4'hb
`define MTC_EXC_IMIS 4'h0
`define MTC_EXC_IACC 4'h1
`define MTC_EXC_ILL 4'h2
`define MTC_EXC_LMIS 4'h4
`define MTC_EXC_LACC 4'h5
`define MTC_EXC_SMIS 4'h6
`define MTC_EXC_SACC 4'h7
`define MTC_EXC_ECALL_U 4'h8
`define MTC_OPC_SYSTEM 7'h73
`define MTC_F3_PRIVILEGED_MINOR_FUNCTION 3'h0
`define MTC_F12_USER_TRAP_RETURN 12'h002
`define MTC_F12_SUPERVISOR_TRAP_RETURN 12'h102
`define MTC_F12_HYPERVISOR_TRAP_RETURN 12'h202
`define MTC_F12_MACHINE_TRAP_RETURN 12'h302
`define MTC_F12_WFI 12'h105
`define MTC_PC_STEP 64'h0000_0000_0000_0004
`define MTC_RST_CAUSE 64'h0000_0000_0000_0000
`define MTC_RST_VEC 64'h0000_0000_0000_1000
`define MTC_PRV_U 2'h0
`define MTC_PRV_S 2'h1
`define MTC_PRV_H 2'h2
`define MTC_PRV_M 2'h3
`define MTC_VM_BARE 5'h00
`endif

// ### verilog/mtc_pkg.sv
// Types of the machine trap cause and return unit.
// Assumes nothing of its surroundings.
package mtc_pkg;
   typedef enum logic [2:0] {
      MTC_RUN = 3'b001,
      MTC_WAIT = 3'b010,
      MTC_WAKE = 3'b100
   } mtc_state_t;
   typedef enum logic [2:0] {
      MTC_RET_NONE = 3'h0,
      MTC_RET_U = 3'h1,
      MTC_RET_S = 3'h2,
      MTC_RET_H = 3'h3,
      MTC_RET_M = 3'h4
   } mtc_ret_t;
endpackage : mtc_pkg

// ### verilog/mtc_decode.sv
// Decoder for trap-return and wait-for-interrupt words.
// Assumes a 32-bit instruction word from the same clock domain.
`timescale 1ns/1ps
`include "mtc_map.svh"
module mtc_decode (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic [31:0] insn_i,
   input wire logic [1:0] prv_i,
   output mtc_pkg::mtc_ret_t ret_o,
   output logic wfi_o,
   output logic ill_o
);
   logic base;
   logic regs_zero;
   mtc_pkg::mtc_ret_t ret_d;
   logic wfi_d;
   logic ill_d;
   assign base = (insn_i[6:0] == `MTC_OPC_SYSTEM) && (insn_i[14:12] == `MTC_F3_PRIVILEGED_MINOR_FUNCTION);
   assign regs_zero = (insn_i[19:15] == 5'h00) && (insn_i[11:7] == 5'h00);
   always_comb begin
      ret_d = mtc_pkg::MTC_RET_NONE;
      wfi_d = 1'b0;
      ill_d = 1'b0;
      if (base) begin
         case (insn_i[31:20])
            `MTC_F12_MACHINE_TRAP_RETURN: ret_d = mtc_pkg::MTC_RET_M;
            `MTC_F12_HYPERVISOR_TRAP_RETURN: ret_d = mtc_pkg::MTC_RET_H;
            `MTC_F12_SUPERVISOR_TRAP_RETURN: ret_d = mtc_pkg::MTC_RET_S;
            `MTC_F12_USER_TRAP_RETURN: ret_d = mtc_pkg::MTC_RET_U;
            `MTC_F12_WFI: wfi_d = 1'b1;
            default: ret_d = mtc_pkg::MTC_RET_NONE;
         endcase
         // Return level must not exceed current level
         if (ret_d != mtc_pkg::MTC_RET_NONE) begin
            if (!regs_zero || ({1'b0, prv_i} < 3'(ret_d - 3'h1))) begin
               ill_d = 1'b1;
               ret_d = mtc_pkg::MTC_RET_NONE;
            end
         end
         // Non-zero register fields are illegal
         if (wfi_d && !regs_zero) begin
            ill_d = 1'b1;
            wfi_d = 1'b0;
         end
         // User mode wait needs user interrupts, absent here
         if (wfi_d && prv_i == `MTC_PRV_U) begin
            ill_d = 1'b1;
            wfi_d = 1'b0;
         end
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ret_o <= mtc_pkg::MTC_RET_NONE;
         wfi_o <= 1'b0;
         ill_o <= 1'b0;
      end else if (ce_i) begin
         ret_o <= ret_d;
         wfi_o <= wfi_d;
         ill_o <= ill_d;
      end
   end
endmodule : mtc_decode

// ### verilog/mtc_wb_regs.sv
// Wishbone classic slave front end: decodes and acknowledges.
// Assumes a single-clock master holding requests until ack.
`timescale 1ns/1ps
`include "mtc_map.svh"
module mtc_wb_regs (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [5:0] adr_i,
   output logic ack_o,
   output logic wr_o,
   output logic [3:0] idx_o,
   output logic hi_o
);
   logic go;
   // One access per request; ack drops the cycle after it rises
   assign go = cyc_i && stb_i && !ack_o;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_o <= 1'b0;
      end else if (ce_i) begin
         ack_o <= go;
      end
   end
   assign wr_o = go;
   assign idx_o = adr_i[5:2];
   assign hi_o = 1'b0;
endmodule : mtc_wb_regs

// ### verilog/mtc_trap_unit.sv
// Machine trap cause and return unit with a Wishbone register port.
// Assumes the pipeline reports traps and retirements on clk_i.
`timescale 1ns/1ps
`include "mtc_map.svh"
module mtc_trap_unit (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic insn_valid_i,
   input wire logic [31:0] insn_i,
   input wire logic [63:0] insn_pc_i,
   input wire logic exc_valid_i,
   input wire logic [3:0] exc_code_i,
   input wire logic [63:0] exc_addr_i,
   input wire logic [11:0] irq_pending_i,
   output logic [1:0] privileged_minor_function_o,
   output logic machine_global_irq_enable_o,
   output logic modify_privilege_bit_o,
   output logic [4:0] translation_mode_field_o,
   output logic stall_o,
   output logic redirect_o,
   output logic [63:0] redirect_pc_o,
   output logic trap_o
);
   logic [63:0] epc_q;
   logic [63:0] cause_q;
   logic [63:0] bad_q;
   logic [63:0] xepc_q;
   logic [11:0] irq_en_q;
   logic [1:0] privileged_minor_function_q;
   logic mie_q;
   logic mpie_q;
   logic [1:0] mpp_q;
   logic modify_privilege_bit_q;
   logic [4:0] vm_q;
   logic [63:0] pc_q;
   logic [63:0] pc_d;
   logic [11:0] irq_s1_q;
   logic [11:0] irq_s2_q;
   logic [31:0] rd_d;
   logic wr_go;
   logic [3:0] idx;
   logic hi_unused;
   logic wb_ack;
   logic [31:0] insn_q;
   logic insn_v_q;
   mtc_pkg::mtc_ret_t ret;
   logic wait_for_interrupt_insn;
   logic ill;
   mtc_pkg::mtc_state_t st_q;
   mtc_pkg::mtc_state_t st_d;
   logic local_irq;
   logic take_irq;
   logic [3:0] irq_code;
   logic take_exc;
   logic [3:0] exc_code;

   // Forces alignment; no compressed support so two bits clear
   function automatic logic [63:0] mtc_align(input logic [63:0] a);
      mtc_align = {a[63:2], 2'b00};
   endfunction : mtc_align

   // Merge a 32-bit half under byte enables
   function automatic logic [31:0] mtc_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         mtc_merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
      end
   endfunction : mtc_merge

   // Highest supported pending code wins
   function automatic logic [3:0] mtc_prio(input logic [11:0] p);
      mtc_prio = 4'h0;
      for (int i = 0; i < 12; i++) begin
         if (p[i]) mtc_prio = 4'(i);
      end
   endfunction : mtc_prio

   mtc_wb_regs u_bus (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .cyc_i(wb_cyc_i),
      .stb_i(wb_stb_i),
      .adr_i(wb_adr_i),
      .ack_o(wb_ack),
      .wr_o(wr_go),
      .idx_o(idx),
      .hi_o(hi_unused)
   );

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         insn_q <= 32'h0000_0000;
         insn_v_q <= 1'b0;
      end else if (ce_i) begin
         insn_q <= (insn_valid_i && st_q == mtc_pkg::MTC_RUN) ? insn_i : 32'h0000_0000;
         insn_v_q <= insn_valid_i && (st_q == mtc_pkg::MTC_RUN);
      end
   end

   mtc_decode u_dec (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .insn_i(insn_q),
      .prv_i(privileged_minor_function_q),
      .ret_o(ret),
      .wfi_o(wait_for_interrupt_insn),
      .ill_o(ill)
   );

   // Pending lines come from other domains
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_s1_q <= 12'h000;
         irq_s2_q <= 12'h000;
      end else if (ce_i) begin
         irq_s1_q <= irq_pending_i;
         irq_s2_q <= irq_s1_q;
      end
   end

   // Individual enables only; global enable ignored for wake
   assign local_irq = |(irq_s2_q & irq_en_q);
   assign irq_code = mtc_prio(irq_s2_q & irq_en_q);
   assign take_irq = local_irq && (mie_q || privileged_minor_function_q != `MTC_PRV_M);
   assign take_exc = (exc_valid_i && exc_code_i <= `MTC_CODE_MAX_EXC) || ill;
   // Decoder illegal wins its code
   assign exc_code = ill ? `MTC_EXC_ILL : exc_code_i;

   always_comb begin
      st_d = st_q;
      case (st_q)
         mtc_pkg::MTC_RUN: if (wait_for_interrupt_insn && !take_exc) st_d = mtc_pkg::MTC_WAIT;
         mtc_pkg::MTC_WAIT: if (local_irq) st_d = mtc_pkg::MTC_WAKE;
         mtc_pkg::MTC_WAKE: st_d = mtc_pkg::MTC_RUN;
         default: st_d = mtc_pkg::MTC_RUN;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= mtc_pkg::MTC_RUN;
      end else if (ce_i) begin
         st_q <= st_d;
      end
   end

   // Pc of decoded instruction trails by one; held so a wake sees the wait's pc
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pc_q <= `MTC_RST_VEC;
         pc_d <= `MTC_RST_VEC;
      end else if (ce_i) begin
         if (insn_valid_i && st_q == mtc_pkg::MTC_RUN) pc_d <= insn_pc_i;
         pc_q <= pc_d;
      end
   end

   // Trap bookkeeping; exceptions outrank interrupts
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         epc_q <= 64'h0000_0000_0000_0000;
         cause_q <= `MTC_RST_CAUSE;
         bad_q <= 64'h0000_0000_0000_0000;
      end else if (ce_i) begin
         if (take_exc && st_q == mtc_pkg::MTC_RUN) begin
            epc_q <= mtc_align(pc_q);
            cause_q <= {60'h0, exc_code};
            case (exc_code)
               `MTC_EXC_IMIS, `MTC_EXC_IACC, `MTC_EXC_LMIS, `MTC_EXC_LACC,
               `MTC_EXC_SMIS, `MTC_EXC_SACC: bad_q <= exc_addr_i;
               default: bad_q <= bad_q;
            endcase
         end else if (st_q == mtc_pkg::MTC_WAKE && take_irq) begin
            epc_q <= mtc_align(pc_q + `MTC_PC_STEP);
            cause_q <= {1'b1, 59'h0, irq_code};
         end else if (take_irq && st_q == mtc_pkg::MTC_RUN && insn_v_q) begin
            epc_q <= mtc_align(pc_q);
            cause_q <= {1'b1, 59'h0, irq_code};
         end else if (wr_go && wb_we_i) begin
            case (idx)
               `MTC_ADR_EPC: epc_q <= mtc_align({32'h0, mtc_merge(epc_q[31:0], wb_dat_i,
                                                                  wb_sel_i)});
               // Codes above eleven are dropped
               `MTC_ADR_CAUSE: if (wb_dat_i[3:0] <= `MTC_CODE_MAX_INT)
                  cause_q <= {wb_dat_i[31], 59'h0, wb_dat_i[3:0]};
               `MTC_ADR_BAD: bad_q <= {32'h0, mtc_merge(bad_q[31:0], wb_dat_i, wb_sel_i)};
               default: bad_q <= bad_q;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_en_q <= 12'h000;
         xepc_q <= 64'h0000_0000_0000_0000;
      end else if (ce_i && wr_go && wb_we_i) begin
         if (idx == `MTC_ADR_IE) irq_en_q <= wb_dat_i[11:0];
         if (idx == `MTC_ADR_RSTV) xepc_q <= mtc_align({32'h0, wb_dat_i});
      end
   end

   // Privilege stack; reset to machine, bare
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         privileged_minor_function_q <= `MTC_PRV_M;
         mie_q <= 1'b0;
         mpie_q <= 1'b0;
         mpp_q <= `MTC_PRV_M;
         modify_privilege_bit_q <= 1'b0;
         vm_q <= `MTC_VM_BARE;
      end else if (ce_i) begin
         if ((take_exc && st_q == mtc_pkg::MTC_RUN) ||
             (take_irq && st_q == mtc_pkg::MTC_WAKE) ||
             (take_irq && st_q == mtc_pkg::MTC_RUN && insn_v_q)) begin
            mpie_q <= mie_q;
            mie_q <= 1'b0;
            mpp_q <= privileged_minor_function_q;
            privileged_minor_function_q <= `MTC_PRV_M;
         end else if (ret == mtc_pkg::MTC_RET_M) begin
            mie_q <= mpie_q;
            mpie_q <= 1'b1;
            privileged_minor_function_q <= mpp_q;
            mpp_q <= `MTC_PRV_U;
         end else if (wr_go && wb_we_i && idx == `MTC_ADR_STAT) begin
            mie_q <= wb_dat_i[3];
            modify_privilege_bit_q <= wb_dat_i[17];
         end
      end
   end

   // Redirects: trap, return, wake; wait as nop is legal but unused
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         redirect_o <= 1'b1;
         redirect_pc_o <= `MTC_RST_VEC;
         trap_o <= 1'b0;
      end else if (ce_i) begin
         redirect_o <= 1'b0;
         trap_o <= 1'b0;
         if (take_exc && st_q == mtc_pkg::MTC_RUN) begin
            redirect_o <= 1'b1;
            trap_o <= 1'b1;
            redirect_pc_o <= xepc_q;
         end else if (take_irq && st_q == mtc_pkg::MTC_RUN && insn_v_q) begin
            redirect_o <= 1'b1;
            trap_o <= 1'b1;
            redirect_pc_o <= xepc_q;
         end else if (ret == mtc_pkg::MTC_RET_M) begin
            redirect_o <= 1'b1;
            redirect_pc_o <= epc_q;
         end else if (ret != mtc_pkg::MTC_RET_NONE) begin
            redirect_o <= 1'b1;
            redirect_pc_o <= xepc_q;
         end else if (st_q == mtc_pkg::MTC_WAKE) begin
            redirect_o <= 1'b1;
            trap_o <= take_irq;
            redirect_pc_o <= take_irq ? xepc_q : mtc_align(pc_q + `MTC_PC_STEP);
         end
      end
   end

   always_comb begin
      case (idx)
         `MTC_ADR_EPC: rd_d = epc_q[31:0];
         `MTC_ADR_CAUSE: rd_d = {cause_q[63], 27'h0, cause_q[3:0]};
         `MTC_ADR_BAD: rd_d = bad_q[31:0];
         `MTC_ADR_STAT: rd_d = {14'h0, modify_privilege_bit_q, 13'h0, mie_q, 3'h0};
         `MTC_ADR_PCLO: rd_d = pc_q[31:0];
         `MTC_ADR_PCHI: rd_d = {27'h0, st_q, privileged_minor_function_q};
         `MTC_ADR_IE: rd_d = {20'h0, irq_en_q};
         `MTC_ADR_RSTV: rd_d = xepc_q[31:0];
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wb_dat_o <= 32'h0000_0000;
         privileged_minor_function_o <= `MTC_PRV_M;
         machine_global_irq_enable_o <= 1'b0;
         modify_privilege_bit_o <= 1'b0;
         translation_mode_field_o <= `MTC_VM_BARE;
         stall_o <= 1'b0;
      end else if (ce_i) begin
         wb_dat_o <= wr_go ? rd_d : 32'h0000_0000;
         privileged_minor_function_o <= privileged_minor_function_q;
         machine_global_irq_enable_o <= mie_q;
         modify_privilege_bit_o <= modify_privilege_bit_q;
         translation_mode_field_o <= vm_q;
         stall_o <= (st_d == mtc_pkg::MTC_WAIT);
      end
   end
   assign wb_ack_o = wb_ack;

   AST_EPC_ALIGN: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      epc_q[1:0] == 2'b00) else $error("return address misaligned");
   AST_CAUSE_MID: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cause_q[62:4] == 59'h0) else $error("cause middle bits set");
   AST_EXC_FLAG: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ce_i && take_exc && st_q == mtc_pkg::MTC_RUN |=> !cause_q[63])
      else $error("exception flagged as interrupt");
   AST_WAKE_EPC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ce_i && st_q == mtc_pkg::MTC_WAKE && take_irq && !take_exc
      |=> epc_q == mtc_align($past(pc_q) + `MTC_PC_STEP))
      else $error("wake trap epc wrong");
   AST_WAKE_LOCAL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ce_i && st_q == mtc_pkg::MTC_WAIT && !local_irq |=> st_q != mtc_pkg::MTC_WAKE)
      else $error("woke without enabled irq");
   AST_MACHINE_TRAP_RETURN_PC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ce_i && ret == mtc_pkg::MTC_RET_M && !take_exc && !(take_irq && insn_v_q)
      |=> redirect_o && redirect_pc_o == $past(epc_q))
      else $error("machine return pc wrong");
   AST_ILL_CODE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ce_i && ill && st_q == mtc_pkg::MTC_RUN |=> cause_q[3:0] == `MTC_EXC_ILL)
      else $error("illegal code wrong");
   AST_BAD_ADDR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ce_i && exc_valid_i && !ill && st_q == mtc_pkg::MTC_RUN && exc_code_i == `MTC_EXC_LACC
      |=> bad_q == $past(exc_addr_i)) else $error("fault address not saved");
   COV_WAIT: cover property (@(posedge clk_i) st_q == mtc_pkg::MTC_WAIT ##1 st_q == mtc_pkg::MTC_WAKE);
   COV_MACHINE_TRAP_RETURN: cover property (@(posedge clk_i) ret == mtc_pkg::MTC_RET_M);
   COV_ECALL: cover property (@(posedge clk_i) take_exc && exc_code == `MTC_EXC_ECALL_U);
endmodule : mtc_trap_unit

// ### tb/mtc_pipe_model.sv
// Pipeline and interrupt source model facing the trap unit.
// Assumes commands from the bench, one cycle wide, on clk_i.
`timescale 1ns/1ps
module mtc_pipe_model (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic stall_i,
   input wire logic go_i,
   input wire logic [31:0] word_i,
   input wire logic [63:0] pc_i,
   input wire logic exc_i,
   input wire logic [3:0] code_i,
   input wire logic [63:0] addr_i,
   input wire logic [11:0] irq_i,
   output logic insn_valid_o,
   output logic [31:0] insn_o,
   output logic [63:0] insn_pc_o,
   output logic exc_valid_o,
   output logic [3:0] exc_code_o,
   output logic [63:0] exc_addr_o,
   output logic [11:0] irq_pending_o
);
   logic [1:0] exc_pipe_q;
   logic [3:0] code_p1_q;
   logic [3:0] code_p2_q;
   logic [63:0] addr_p1_q;
   logic [63:0] addr_p2_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         insn_valid_o <= 1'b0;
         exc_pipe_q <= 2'b00;
         exc_valid_o <= 1'b0;
         irq_pending_o <= 12'h000;
      end else begin
         // No issue while the hart is held in wait
         insn_valid_o <= go_i & ~stall_i;
         // Faults trail their word by two cycles, in step with the unit's decode
         exc_pipe_q <= {exc_pipe_q[0], exc_i & go_i & ~stall_i};
         exc_valid_o <= exc_pipe_q[1];
         irq_pending_o <= irq_i;
      end
   end
   // Idle buses toggle so stale words never pass for fresh ones
   always_ff @(posedge clk_i) begin
      insn_o <= go_i ? word_i : ~insn_o;
      insn_pc_o <= go_i ? pc_i : ~insn_pc_o;
      code_p1_q <= code_i;
      code_p2_q <= code_p1_q;
      addr_p1_q <= addr_i;
      addr_p2_q <= addr_p1_q;
      exc_code_o <= exc_pipe_q[1] ? code_p2_q : ~exc_code_o;
      exc_addr_o <= exc_pipe_q[1] ? addr_p2_q : ~exc_addr_o;
   end
endmodule : mtc_pipe_model

// ### tb/testbench.sv
// Self-checking bench for the machine trap cause and return unit.
// Assumes the design files and the pipeline model are compiled first.
`timescale 1ns/1ps
`include "mtc_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, go = 1'b0, exc = 1'b0;
   logic [5:0] wb_adr = 6'h00;
   logic [31:0] wb_dat = 32'h0, wb_q, word = 32'h0, q, v, prev;
   logic [63:0] pc = 64'h0, addr = 64'h0, p, a, rd_pc;
   logic [3:0] code = 4'h0;
   logic [11:0] irq = 12'h000, irq_pend;
   logic insn_valid, exc_valid, privileged_minor_function_m, modify_privilege_bit, stall, redir, trap, rd_trap;
   logic [31:0] insn;
   logic [63:0] insn_pc, exc_addr, redir_pc;
   logic [3:0] exc_code;
   logic [1:0] privileged_minor_function;
   logic [4:0] vm;
   int rd_cnt = 0, miscompares = 0, n_checks = 0, cycles = 0;

   always #4 clk_i = ~clk_i;

   mtc_trap_unit i_mtc_trap_unit (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
      .insn_valid_i(insn_valid), .insn_i(insn), .insn_pc_i(insn_pc), .exc_valid_i(exc_valid),
      .exc_code_i(exc_code), .exc_addr_i(exc_addr), .irq_pending_i(irq_pend), .privileged_minor_function_o(privileged_minor_function),
      .machine_global_irq_enable_o(privileged_minor_function_m), .modify_privilege_bit_o(modify_privilege_bit),
      .translation_mode_field_o(vm), .stall_o(stall), .redirect_o(redir),
      .redirect_pc_o(redir_pc), .trap_o(trap));
   mtc_pipe_model i_mtc_pipe_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .stall_i(stall),
      .go_i(go), .word_i(word), .pc_i(pc), .exc_i(exc), .code_i(code), .addr_i(addr),
      .irq_i(irq), .insn_valid_o(insn_valid), .insn_o(insn), .insn_pc_o(insn_pc),
      .exc_valid_o(exc_valid), .exc_code_o(exc_code), .exc_addr_o(exc_addr),
      .irq_pending_o(irq_pend));

   function automatic logic [31:0] enc(input logic [11:0] f12, input logic [4:0] r);
      enc = {f12, r, `MTC_F3_PRIVILEGED_MINOR_FUNCTION, r, `MTC_OPC_SYSTEM};
   endfunction : enc
   function automatic logic bad_kept(input logic [3:0] c);
      bad_kept = (c == `MTC_EXC_IMIS) || (c == `MTC_EXC_IACC) || (c >= `MTC_EXC_LMIS &&
         c <= `MTC_EXC_SACC);
   endfunction : bad_kept

   task wrap_up;
      if (miscompares == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   // Sampled at the edge, so a redirect pulse is seen before its NBA lands
   always @(posedge clk_i) begin
      cycles++;
      if (redir === 1'b1 && reset_n_i === 1'b1) begin
         rd_pc <= redir_pc;
         rd_trap <= trap;
         rd_cnt <= rd_cnt + 1;
      end
      if (cycles == 5000) begin
         miscompares++;
         wrap_up();
      end
   end

   task wb(input logic we, input logic [3:0] idx, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= {idx, 2'b00};
      wb_dat <= d;
      @(posedge clk_i);
      while (wb_ack !== 1'b1) @(posedge clk_i);
      q = wb_q;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb

   task issue(input logic [31:0] w, input logic [63:0] ip, input logic e, input logic [3:0] c,
         input logic [63:0] ia);
      @(posedge clk_i);
      go <= 1'b1;
      word <= w;
      pc <= ip;
      exc <= e;
      code <= c;
      addr <= ia;
      @(posedge clk_i);
      go <= 1'b0;
      exc <= 1'b0;
   endtask : issue

   // Bounded wait; a missing redirect counts against the run
   task wait_redir;
      int n0;
      int k;
      n0 = rd_cnt;
      k = 0;
      while (rd_cnt == n0 && k < 30) begin
         @(posedge clk_i);
         k++;
      end
      `CHK(rd_cnt != n0, 1'b1)
   endtask : wait_redir

   initial begin
      void'($urandom(32'h1846));
      repeat (10) @(posedge clk_i);
      `CHK(privileged_minor_function, `MTC_PRV_M)
      `CHK({privileged_minor_function_m, modify_privilege_bit, vm}, {2'b00, `MTC_VM_BARE})
      `CHK(redir_pc, `MTC_RST_VEC)
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1'b1;
      wb(1'b0, 4'h1, 32'h0);
      `CHK(q, `MTC_RST_CAUSE)
      prev = q;
      wb(1'b0, 4'h8, 32'h0);
      `CHK(q, 32'h0)
      v = $urandom;
      wb(1'b1, 4'h0, v | 32'h3);
      wb(1'b0, 4'h0, 32'h0);
      `CHK(q, v & 32'hffff_fffc)
      // Unsupported codes must leave the last legal value in place
      for (int c = 0; c < 16; c++) begin
         wb(1'b1, 4'h1, {1'b1, 27'h0, c[3:0]});
         wb(1'b0, 4'h1, 32'h0);
         if (c < 12)
            prev = {1'b1, 27'h0, c[3:0]};
         `CHK(q, prev)
      end
      wb(1'b1, 4'h1, 32'h0000_0ff3);
      wb(1'b0, 4'h1, 32'h0);
      `CHK(q, 32'h3)
      wb(1'b1, 4'h7, 32'h0000_2000);
      for (int c = 0; c < 12; c++) begin
         p = {32'h0, $urandom & 32'hffff_fffc};
         a = {32'h0, $urandom};
         issue(32'h0000_0013, p, 1'b1, c[3:0], a);
         wait_redir();
         `CHK(rd_trap, 1'b1)
         wb(1'b0, 4'h0, 32'h0);
         `CHK(q, p[31:0])
         wb(1'b0, 4'h1, 32'h0);
         `CHK(q, {28'h0, c[3:0]})
         wb(1'b0, 4'h2, 32'h0);
         if (bad_kept(c[3:0]))
            `CHK(q, a[31:0])
      end
      v = $urandom & 32'hffff_fffc;
      wb(1'b1, 4'h0, v);
      issue(enc(`MTC_F12_MACHINE_TRAP_RETURN, 5'h0), 64'h3000, 1'b0, 4'h0, 64'h0);
      wait_redir();
      `CHK(rd_pc, {32'h0, v})
      `CHK(rd_trap, 1'b0)
      issue(enc(`MTC_F12_WFI, 5'h1), 64'h4000, 1'b0, 4'h0, 64'h0);
      wait_redir();
      wb(1'b0, 4'h1, 32'h0);
      `CHK({rd_trap, q}, {1'b1, 28'h0, `MTC_EXC_ILL})
      // Pending but not enabled line must not end the wait
      wb(1'b1, 4'h6, 32'h0000_0080);
      irq <= 12'h008;
      issue(enc(`MTC_F12_WFI, 5'h0), 64'h5000, 1'b0, 4'h0, 64'h0);
      repeat (8) @(posedge clk_i);
      `CHK(stall, 1'b1)
      irq <= 12'h088;
      wait_redir();
      `CHK({rd_trap, rd_pc}, {1'b0, 64'h5000 + `MTC_PC_STEP})
      irq <= 12'h000;
      wb(1'b1, 4'h3, 32'h0000_0008);
      issue(enc(`MTC_F12_WFI, 5'h0), 64'h6000, 1'b0, 4'h0, 64'h0);
      repeat (4) @(posedge clk_i);
      irq <= 12'h080;
      wait_redir();
      irq <= 12'h000;
      `CHK(rd_trap, 1'b1)
      wb(1'b0, 4'h0, 32'h0);
      `CHK(q, 32'h6004)
      wb(1'b0, 4'h1, 32'h0);
      `CHK(q, 32'h8000_0007)
      wrap_up();
   end
endmodule : testbench
